// *** hw/zisf_regs_top.sv ***
`timescale 1ns/1ps
module zisf_regs_top
   import zisf_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        zStep,
   input  wire logic        fbWrite,
   input  wire logic [31:0] fbData,
   input  wire logic        ctWrite,
   input  wire logic [31:0] ctData,
   output logic      [35:0] zValue,
   output logic      [31:0] depthWord,
   output logic      [7:0]  stencilRef,
   output logic             zBusy,
   output logic      [31:0] fgColour,
   output logic      [31:0] substMask,
   output logic             substValid
);
   // Bus phase tracking
   logic        wrPend_ff;
   logic [7:0]  wrAddr_ff;
   logic [31:0] hrdata_ff;
   logic        addrPhase;
   logic        rdPhase;
   logic [7:0]  rdAddr;

   // Stored register fields
   logic [7:0]  stencil_ff;
   logic [3:0]  zStartTop_ff;
   logic [31:0] zStartLow_ff;
   logic [3:0]  zStepTop_ff;
   logic [31:0] zStepLow_ff;
   logic [31:0] fg_ff;
   logic [31:0] pattern_ff;
   zisf_mode_t  mode_ff;
   logic        keepZ_ff;

   // Next values
   logic [7:0]  nxt_stencil;
   logic [3:0]  nxt_zStartTop;
   logic [31:0] nxt_zStartLow;
   logic [3:0]  nxt_zStepTop;
   logic [31:0] nxt_zStepLow;
   logic [31:0] nxt_fg;
   logic [31:0] nxt_pattern;
   zisf_mode_t  nxt_mode;
   logic        nxt_keepZ;
   logic [31:0] nxt_rdata;

   // Write strobes in the data phase
   logic        wrZHi;
   logic        wrZLo;
   logic        wrSHi;
   logic        wrSLo;
   logic        wrFg;
   logic        wrPat;
   logic        wrCtrl;
   logic        startWr;
   logic        modeOk;

   // Interpolator view
   logic [35:0] zStartVal;
   logic [35:0] zStepVal;
   logic [35:0] zAcc;
   logic [35:0] zInc;
   logic [15:0] zRemain;
   logic [31:0] ctrlWord;
   logic [31:0] statusWord;

   // Address phase decode; only the low byte selects a word
   assign addrPhase = hsel && htrans[1] && hready;
   assign rdPhase   = addrPhase && !hwrite;
   assign rdAddr    = haddr[7:0] & ZISF_OFS_MASK;

   // Zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;

   // Capture address phase of a write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrPend_ff <= 1'b0;
         wrAddr_ff <= '0;
      end else begin
         wrPend_ff <= addrPhase && hwrite;
         if (addrPhase) wrAddr_ff <= rdAddr;
      end
   end

   // Data phase strobes; unmapped offsets match none
   assign wrZHi  = wrPend_ff && (wrAddr_ff == ZISF_OFS_ZSTART_HI);
   assign wrZLo  = wrPend_ff && (wrAddr_ff == ZISF_OFS_ZSTART_LO);
   assign wrSHi  = wrPend_ff && (wrAddr_ff == ZISF_OFS_ZSTEP_HI);
   assign wrSLo  = wrPend_ff && (wrAddr_ff == ZISF_OFS_ZSTEP_LO);
   assign wrPat  = wrPend_ff && (wrAddr_ff == ZISF_OFS_PATTERN);
   assign wrCtrl = wrPend_ff && (wrAddr_ff == ZISF_OFS_CTRL);
   assign wrFg   = wrPend_ff && ((wrAddr_ff == ZISF_OFS_FG) ||
                                 (wrAddr_ff == ZISF_OFS_RED_STEP) ||
                                 (wrAddr_ff == ZISF_OFS_BLUE_STEP));
   assign startWr = wrPend_ff && ((wrAddr_ff == ZISF_OFS_SLOPE) ||
                                  (wrAddr_ff == ZISF_OFS_SPAN));

   // Field updates; reserved bits are simply not stored
   // stencil reference field
   assign nxt_stencil   = wrZHi ? hwdata[ZISF_STENCIL_MSB:ZISF_STENCIL_LSB] : stencil_ff;
   assign nxt_zStartTop = wrZHi ? hwdata[ZISF_HI_INT_MSB:0] : zStartTop_ff;
   assign nxt_zStartLow = wrZLo ? hwdata : zStartLow_ff;
   assign nxt_zStepTop  = wrSHi ? hwdata[ZISF_HI_INT_MSB:0] : zStepTop_ff;
   assign nxt_zStepLow  = wrSLo ? hwdata : zStepLow_ff;
   assign nxt_fg        = wrFg ? hwdata : fg_ff;
   assign nxt_pattern   = wrPat ? hwdata : pattern_ff;
   // Illegal mode codes fall back to plain writes
   assign modeOk        = (hwdata[ZISF_MODE_MSB:0] <= ZISF_MODE_TOP);
   assign nxt_mode      = !wrCtrl ? mode_ff :
                          modeOk  ? zisf_mode_t'(hwdata[ZISF_MODE_MSB:0]) : ZISF_SIMPLE;
   assign nxt_keepZ     = wrCtrl ? hwdata[ZISF_KEEPZ_BIT] : keepZ_ff;

   // Register storage
   // cleared at reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stencil_ff   <= ZISF_RST_WORD[7:0];
         zStartTop_ff <= ZISF_RST_WORD[3:0];
         zStartLow_ff <= ZISF_RST_WORD;
         zStepTop_ff  <= ZISF_RST_WORD[3:0];
         zStepLow_ff  <= ZISF_RST_WORD;
         fg_ff        <= ZISF_RST_FG;
         pattern_ff   <= ZISF_RST_WORD;
         mode_ff      <= ZISF_SIMPLE;
         keepZ_ff     <= 1'b0;
      end else begin
         stencil_ff   <= nxt_stencil;
         zStartTop_ff <= nxt_zStartTop;
         zStartLow_ff <= nxt_zStartLow;
         zStepTop_ff  <= nxt_zStepTop;
         zStepLow_ff  <= nxt_zStepLow;
         fg_ff        <= nxt_fg;
         pattern_ff   <= nxt_pattern;
         mode_ff      <= nxt_mode;
         keepZ_ff     <= nxt_keepZ;
      end
   end

   // 24.12 operands assembled from the two words
   // start integer and fraction
   assign zStartVal = {zStartTop_ff, zStartLow_ff};
   assign zStepVal  = {zStepTop_ff, zStepLow_ff};

   // Interpolator; count comes from the low half of the start write
   zisf_z_interp u_interp (
      .clk       (clk),
      .resetn    (resetn),
      .load      (startWr),
      .loadStart (!keepZ_ff),
      .startVal  (zStartVal),
      .incVal    (zStepVal),
      .count     (hwdata[ZISF_CNT_W-1:0]),
      .stepEn    (zStep),
      .acc_ff    (zAcc),
      .inc_ff    (zInc),
      .remain_ff (zRemain),
      .busy      (zBusy)
   );

   // Substitution mask tracking
   zisf_subst u_subst (
      .clk           (clk),
      .resetn        (resetn),
      .mode          (mode_ff),
      .opStart       (startWr),
      .pattern       (pattern_ff),
      .fbWrite       (fbWrite),
      .fbData        (fbData),
      .ctWrite       (ctWrite),
      .ctData        (ctData),
      .substMask_ff  (substMask),
      .substValid_ff (substValid)
   );

   // Outputs to the pixel pipe
   assign zValue     = zAcc;
   assign stencilRef = stencil_ff;
   assign fgColour   = fg_ff;
   assign depthWord  = {stencil_ff, zAcc[ZISF_Z_W-1:ZISF_FRAC_W]};

   // Read words; writable fields built from next values so a write right before is seen
   assign ctrlWord   = {28'h0000000, nxt_keepZ, nxt_mode};
   assign statusWord = {zRemain, 15'h0000, zBusy};
   assign nxt_rdata =
      (rdAddr == ZISF_OFS_ZSTART_HI) ? {nxt_stencil, 20'h00000, nxt_zStartTop} :
      (rdAddr == ZISF_OFS_ZSTART_LO) ? nxt_zStartLow :
      (rdAddr == ZISF_OFS_ZSTEP_HI)  ? {28'h0000000, nxt_zStepTop} :
      (rdAddr == ZISF_OFS_ZSTEP_LO)  ? nxt_zStepLow :
      (rdAddr == ZISF_OFS_FG)        ? nxt_fg :
      (rdAddr == ZISF_OFS_RED_STEP)  ? nxt_fg :
      (rdAddr == ZISF_OFS_BLUE_STEP) ? nxt_fg :
      (rdAddr == ZISF_OFS_PATTERN)   ? nxt_pattern :
      (rdAddr == ZISF_OFS_CTRL)      ? ctrlWord :
      (rdAddr == ZISF_OFS_STATUS)    ? statusWord :
      (rdAddr == ZISF_OFS_ZACC_LO)   ? zAcc[31:0] :
      (rdAddr == ZISF_OFS_ZACC_HI)   ? {28'h0000000, zAcc[35:32]} : ZISF_RST_WORD;

   // Read data registered at the end of the address phase
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) hrdata_ff <= '0;
      else if (rdPhase) hrdata_ff <= nxt_rdata;
   end

   // Checks
   default clocking dc @(posedge clk); endclocking
   default disable iff (!resetn);

   AST_STENCIL_WRITE:
   assert property (wrZHi |=> stencilRef == $past(hwdata[31:24]))
      else $error("stencil reference not taken from write");

   AST_START_LOAD:
   assert property ((startWr && !keepZ_ff) |=> zValue == $past(zStartVal))
      else $error("start value not loaded");

   AST_KEEP_Z:
   assert property ((startWr && keepZ_ff && !zBusy) |=> zValue == $past(zValue))
      else $error("kept Z value was reloaded");

   AST_INC_LOAD:
   assert property (startWr |=> zInc == $past(zStepVal))
      else $error("increment not loaded on start");

   AST_ACCUMULATE:
   assert property ((zBusy && zStep && !startWr) |=> zValue == $past(zValue) + $past(zInc))
      else $error("accumulator step wrong");

   AST_STEP_COUNT:
   assert property ((startWr && hwdata[ZISF_CNT_W-1:0] == 16'h0002) ##1 (!zStep) ##1
                    (zStep [*2]) |=> !zBusy)
      else $error("step count not honoured");

   AST_DEPTH_WORD:
   assert property (depthWord[23:0] == zValue[35:12] && depthWord[31:24] == stencilRef)
      else $error("depth word packing wrong");

   AST_RESET_CLEAR:
   assert property ($rose(resetn) |-> zStartVal == 36'h0 && zStepVal == 36'h0 &&
                                      stencilRef == 8'h00 && fgColour == 32'h00000000)
      else $error("registers not cleared by reset");

   AST_FG_SHARED:
   assert property ((wrPend_ff && wrAddr_ff == ZISF_OFS_RED_STEP) |=>
                    fgColour == $past(hwdata))
      else $error("red step write missed foreground");

   AST_SUBST_START:
   assert property ((startWr && mode_ff != ZISF_SIMPLE) |=>
                    substValid && substMask == $past(pattern_ff))
      else $error("pattern mask not used on start");

   AST_RSVD_ZERO:
   assert property ((rdPhase && rdAddr == ZISF_OFS_ZSTEP_HI) |=> hrdata[31:4] == 28'h0)
      else $error("reserved bits not zero");

   // Hold, mask-source, zero-count, shared-address, mode and reserved-bit checks; a drifting idle value would corrupt the next span
   AST_IDLE_HOLD:
   assert property ((!zBusy && !startWr) |=> $stable(zValue))
      else $error("z value moved while idle");

   AST_INC_HOLD:
   assert property (!startWr |=> $stable(zInc))
      else $error("increment changed without a start");

   AST_START_ZERO:
   assert property ((startWr && hwdata[ZISF_CNT_W-1:0] == '0) |=> !zBusy)
      else $error("zero count start left busy");

   AST_STENCIL_HOLD:
   assert property (!wrZHi |=> $stable(stencilRef))
      else $error("stencil reference changed without a write");

   AST_FG_HOLD:
   assert property (!wrFg |=> $stable(fgColour))
      else $error("foreground changed without a write");

   AST_BLUE_SHARED:
   assert property ((wrPend_ff && wrAddr_ff == ZISF_OFS_BLUE_STEP) |=>
                    fgColour == $past(hwdata))
      else $error("blue step write missed foreground");

   AST_CT_MASK:
   assert property ((ctWrite && !startWr && mode_ff != ZISF_SIMPLE) |=>
                    substValid && substMask == $past(ctData))
      else $error("copy-target data not used as mask");

   AST_FILL_MASK:
   assert property ((fbWrite && !startWr && !ctWrite &&
                     (mode_ff == ZISF_TFILL || mode_ff == ZISF_OFILL)) |=>
                    substMask == $past(pattern_ff))
      else $error("fill write did not use the pattern");

   AST_SIMPLE_QUIET:
   assert property ((mode_ff == ZISF_SIMPLE) |=> !substValid)
      else $error("substitution in simple mode");

   AST_ILLEGAL_MODE:
   assert property ((wrCtrl && (&hwdata[ZISF_MODE_MSB:0])) |=> mode_ff == ZISF_SIMPLE)
      else $error("illegal mode code not treated as simple");

   AST_ZHI_RSVD:
   assert property ((rdPhase && rdAddr == ZISF_OFS_ZSTART_HI) |=>
                    hrdata[ZISF_STENCIL_LSB-1:ZISF_HI_INT_MSB+1] == '0)
      else $error("reserved start bits not zero");

   COV_LINE_START: cover property (startWr ##1 zBusy ##[1:20] !zBusy);
   COV_KEEP_Z:     cover property (startWr && keepZ_ff);
   COV_FILL_SUBST: cover property (fbWrite && mode_ff == ZISF_TFILL);
   COV_BACK_READ:  cover property (wrZHi && rdPhase && rdAddr == ZISF_OFS_ZSTART_HI);
   COV_SPAN_START: cover property (startWr && wrAddr_ff == ZISF_OFS_SPAN);

endmodule : zisf_regs_top

// *** hw/zisf_pkg.sv ***
package zisf_pkg;

   // Byte offsets of the register words
   localparam logic [7:0] ZISF_OFS_ZSTART_HI = 8'h00;
   localparam logic [7:0] ZISF_OFS_ZSTART_LO = 8'h04;
   localparam logic [7:0] ZISF_OFS_ZSTEP_HI  = 8'h08;
   localparam logic [7:0] ZISF_OFS_ZSTEP_LO  = 8'h0c;
   localparam logic [7:0] ZISF_OFS_FG        = 8'h10;
   localparam logic [7:0] ZISF_OFS_SLOPE     = 8'h14;
   localparam logic [7:0] ZISF_OFS_SPAN      = 8'h18;
   localparam logic [7:0] ZISF_OFS_PATTERN   = 8'h1c;
   localparam logic [7:0] ZISF_OFS_RED_STEP  = 8'h20;
   localparam logic [7:0] ZISF_OFS_BLUE_STEP = 8'h24;
   localparam logic [7:0] ZISF_OFS_CTRL      = 8'h28;
   localparam logic [7:0] ZISF_OFS_STATUS    = 8'h2c;
   localparam logic [7:0] ZISF_OFS_ZACC_LO   = 8'h30;
   localparam logic [7:0] ZISF_OFS_ZACC_HI   = 8'h34;
   localparam logic [7:0] ZISF_OFS_MASK      = 8'hfc;

   // Field positions and widths
   localparam int ZISF_STENCIL_MSB = 31;
   localparam int ZISF_STENCIL_LSB = 24;
   localparam int ZISF_HI_INT_MSB  = 3;
   localparam int ZISF_LO_INT_LSB  = 12;
   localparam int ZISF_FRAC_W      = 12;
   localparam int ZISF_INT_W       = 24;
   localparam int ZISF_Z_W         = 36;
   localparam int ZISF_CNT_W       = 16;
   localparam int ZISF_MODE_MSB    = 2;
   localparam int ZISF_KEEPZ_BIT   = 3;

   // Reset values, unit count and top mode code
   localparam logic [31:0] ZISF_RST_WORD = 32'h0000_0000;
   localparam logic [31:0] ZISF_RST_FG   = 32'h0000_0000;
   localparam logic [15:0] ZISF_CNT_ONE  = 16'h0001;
   localparam logic [2:0]  ZISF_MODE_TOP = 3'h6;

   // Pixel substitution modes
   typedef enum logic [2:0] {
      ZISF_SIMPLE, ZISF_TSTIP, ZISF_OSTIP, ZISF_TLINE, ZISF_OLINE, ZISF_TFILL, ZISF_OFILL
   } zisf_mode_t;

   // Interpolator states
   typedef enum logic {ZISF_IDLE, ZISF_RUN} zisf_zstate_t;

endpackage : zisf_pkg

// *** hw/zisf_z_interp.sv ***
`timescale 1ns/1ps
module zisf_z_interp
   import zisf_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  load,
   input  wire logic                  loadStart,
   input  wire logic [ZISF_Z_W-1:0]   startVal,
   input  wire logic [ZISF_Z_W-1:0]   incVal,
   input  wire logic [ZISF_CNT_W-1:0] count,
   input  wire logic                  stepEn,
   output logic      [ZISF_Z_W-1:0]   acc_ff,
   output logic      [ZISF_Z_W-1:0]   inc_ff,
   output logic      [ZISF_CNT_W-1:0] remain_ff,
   output logic                       busy
);
   zisf_zstate_t            state_ff;
   zisf_zstate_t            nxt_state;
   logic [ZISF_Z_W-1:0]     nxt_acc;
   logic [ZISF_Z_W-1:0]     nxt_inc;
   logic [ZISF_CNT_W-1:0]   nxt_remain;

   // Step sequencing; a fresh load restarts even a running operation
   always_comb begin
      nxt_state  = state_ff;
      nxt_acc    = acc_ff;
      nxt_inc    = inc_ff;
      nxt_remain = remain_ff;
      case (state_ff)
         ZISF_IDLE: nxt_state = ZISF_IDLE;
         ZISF_RUN: begin
            if (stepEn) begin
               nxt_acc    = acc_ff + inc_ff;
               nxt_remain = remain_ff - ZISF_CNT_ONE;
               if (remain_ff == ZISF_CNT_ONE) nxt_state = ZISF_IDLE;
            end
         end
         default: nxt_state = ZISF_IDLE;
      endcase
      if (load) begin
         nxt_inc    = incVal;
         if (loadStart) nxt_acc = startVal;
         nxt_remain = count;
         nxt_state  = (count != '0) ? ZISF_RUN : ZISF_IDLE;
      end
   end

   // Interpolator state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff  <= ZISF_IDLE;
         acc_ff    <= '0;
         inc_ff    <= '0;
         remain_ff <= '0;
      end else begin
         state_ff  <= nxt_state;
         acc_ff    <= nxt_acc;
         inc_ff    <= nxt_inc;
         remain_ff <= nxt_remain;
      end
   end

   assign busy = (state_ff == ZISF_RUN);

endmodule : zisf_z_interp

// *** hw/zisf_subst.sv ***
`timescale 1ns/1ps
module zisf_subst
   import zisf_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire zisf_mode_t  mode,
   input  wire logic        opStart,
   input  wire logic [31:0] pattern,
   input  wire logic        fbWrite,
   input  wire logic [31:0] fbData,
   input  wire logic        ctWrite,
   input  wire logic [31:0] ctData,
   output logic      [31:0] substMask_ff,
   output logic             substValid_ff
);
   logic        substMode;
   logic        fillMode;
   logic [31:0] nxt_mask;
   logic        nxt_valid;

   assign substMode = (mode != ZISF_SIMPLE);
   assign fillMode  = (mode == ZISF_TFILL) || (mode == ZISF_OFILL);
   assign nxt_mask  = opStart  ? pattern :
                      ctWrite  ? ctData  :
                      fillMode ? pattern : fbData;
   assign nxt_valid = substMode && (opStart || fbWrite || ctWrite);

   // Mask holds between events so downstream can sample late
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         substMask_ff  <= '0;
         substValid_ff <= 1'b0;
      end else begin
         substValid_ff <= nxt_valid;
         if (nxt_valid) substMask_ff <= nxt_mask;
      end
   end

endmodule : zisf_subst

// *** bench/z_interpolator_setup_and_foreground_bench.sv ***
`timescale 1ns/1ps
module z_interpolator_setup_and_foreground_bench
   import zisf_pkg::*;
;
   logic        clk      = 1'b0;
   logic        resetn   = 1'b0;
   logic        hsel     = 1'b0;
   logic [31:0] haddr    = 32'h0;
   logic [1:0]  htrans   = 2'h0;
   logic        hwrite   = 1'b0;
   logic [2:0]  hsize    = 3'h2;
   logic [31:0] hwdata   = 32'h0;
   logic        zStep    = 1'b0;
   logic        fbWrite  = 1'b0;
   logic [31:0] fbData   = 32'h0;
   logic        ctWrite  = 1'b0;
   logic [31:0] ctData   = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [35:0] zValue;
   logic [31:0] depthWord;
   logic [7:0]  stencilRef;
   logic        zBusy;
   logic [31:0] fgColour;
   logic [31:0] substMask;
   logic        substValid;
   int          err_count    = 0;
   int          total_checks = 0;

   // Start and step operands shared by the Z scenarios
   localparam logic [31:0] ZHI = 32'h5aff_fff3;
   localparam logic [31:0] ZLO = 32'h1234_5678;
   localparam logic [31:0] SHI = 32'hffff_fff1;
   localparam logic [31:0] SLO = 32'h0002_0800;
   localparam logic [35:0] ZST = {ZHI[3:0], ZLO};
   localparam logic [35:0] ZIN = {SHI[3:0], SLO};
   localparam logic [35:0] ZS2 = ZST + ZIN + ZIN;

   // Free-running clock, 8 ns period
   always #4 clk = ~clk;

   zisf_regs_top dut_u (
      .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .zStep(zStep),
      .fbWrite(fbWrite), .fbData(fbData), .ctWrite(ctWrite), .ctData(ctData),
      .zValue(zValue), .depthWord(depthWord), .stencilRef(stencilRef), .zBusy(zBusy),
      .fgColour(fgColour), .substMask(substMask), .substValid(substValid)
   );

   task automatic summarize();
      if (err_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Bounded wait for an edge with hready high; a hang ends the run
   task automatic waitReady();
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1 && n <= 50) begin
         n++;
         @(posedge clk);
      end
      if (n > 50) begin
         err_count++;
         $display("[FAIL] %0t bus wait timed out", $time);
         summarize();
      end
   endtask : waitReady

   // Single word transfer; address phase held until hready, then data phase
   task automatic busXfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                          output logic [31:0] rd);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, ofs};
      htrans <= 2'b10;
      hwrite <= wr;
      waitReady();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      waitReady();
      rd = hrdata;
   endtask : busXfer

   task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
      logic [31:0] unused;
      busXfer(1'b1, ofs, wd, unused);
      #1;
   endtask : wr

   task automatic rdChk(input logic [7:0] ofs, input logic [31:0] msk, input logic [31:0] exp);
      logic [31:0] d;
      busXfer(1'b0, ofs, 32'h0, d);
      chk({4'h0, d & msk}, {4'h0, exp}, "register read");
   endtask : rdChk

   // Mask source pulse: frame buffer write or copy-target write
   task automatic pulse(input logic isCt, input logic [31:0] d);
      @(posedge clk);
      fbWrite <= ~isCt;
      ctWrite <= isCt;
      fbData  <= d;
      ctData  <= d;
      @(posedge clk);
      fbWrite <= 1'b0;
      ctWrite <= 1'b0;
      #1;
   endtask : pulse

   task automatic substChk(input logic [31:0] exp);
      chk({35'h0, substValid}, 36'h1, "mask pulse");
      chk({4'h0, substMask}, {4'h0, exp}, "mask source");
      @(posedge clk);
      #1;
      chk({35'h0, substValid}, 36'h0, "mask pulse end");
   endtask : substChk

   task automatic tResetVals();
      logic [7:0] ofsList [5];
      ofsList = '{ZISF_OFS_ZSTART_HI, ZISF_OFS_ZSTART_LO, ZISF_OFS_ZSTEP_HI,
                  ZISF_OFS_ZSTEP_LO, ZISF_OFS_FG};
      chk(zValue, 36'h0, "z after reset");
      chk({28'h0, stencilRef}, 36'h0, "stencil after reset");
      chk({4'h0, fgColour}, 36'h0, "fg after reset");
      chk({34'h0, zBusy, hresp}, 36'h0, "busy and resp after reset");
      chk({3'h0, substValid, substMask}, 36'h0, "mask after reset");
      foreach (ofsList[i]) begin
         rdChk(ofsList[i], 32'hffff_ffff, 32'h0);
      end
   endtask : tResetVals

   task automatic tZRegs();
      wr(ZISF_OFS_ZSTART_HI, ZHI);
      wr(ZISF_OFS_ZSTART_LO, ZLO);
      wr(ZISF_OFS_ZSTEP_HI, SHI);
      wr(ZISF_OFS_ZSTEP_LO, SLO);
      chk({28'h0, stencilRef}, 36'h5a, "stencil reference");
      // stencil field read treated as arbitrary
      rdChk(ZISF_OFS_ZSTART_HI, 32'h00ff_ffff, 32'h0000_0003);
      rdChk(ZISF_OFS_ZSTEP_HI, 32'hffff_ffff, 32'h0000_0001);
      rdChk(ZISF_OFS_ZSTART_LO, 32'hffff_ffff, ZLO);
   endtask : tZRegs

   task automatic tInterp();
      wr(ZISF_OFS_CTRL, 32'h0);
      wr(ZISF_OFS_SLOPE, 32'h0000_0002);
      chk(zValue, ZST, "start loaded");
      chk({35'h0, zBusy}, 36'h1, "busy after start");
      @(posedge clk);
      zStep <= 1'b1;
      repeat (2) @(posedge clk);
      zStep <= 1'b0;
      #1;
      chk(zValue, ZST + ZIN + ZIN, "two steps");
      chk({35'h0, zBusy}, 36'h0, "idle after count");
      chk({4'h0, depthWord}, {4'h0, 8'h5a, ZS2[35:12]}, "depth word");
      // Steps while idle are ignored
      @(posedge clk);
      zStep <= 1'b1;
      @(posedge clk);
      zStep <= 1'b0;
      #1;
      chk(zValue, ZST + ZIN + ZIN, "idle step ignored");
      rdChk(ZISF_OFS_ZACC_LO, 32'hffff_ffff, ZS2[31:0]);
      rdChk(ZISF_OFS_ZACC_HI, 32'hffff_ffff, {28'h0, ZS2[35:32]});
   endtask : tInterp

   task automatic tKeepZ();
      logic [35:0] prev;
      prev = zValue;
      wr(ZISF_OFS_ZSTEP_LO, 32'h0000_1001);
      wr(ZISF_OFS_CTRL, 32'h0000_0008);
      wr(ZISF_OFS_SPAN, 32'h0000_0001);
      chk(zValue, prev, "keep z on start");
      rdChk(ZISF_OFS_STATUS, 32'hffff_ffff, 32'h0001_0001);
      @(posedge clk);
      zStep <= 1'b1;
      @(posedge clk);
      zStep <= 1'b0;
      #1;
      chk(zValue, prev + {SHI[3:0], 32'h0000_1001}, "increment reloaded");
      wr(ZISF_OFS_CTRL, 32'h0);
      wr(ZISF_OFS_SPAN, 32'h0);
      chk(zValue, ZST, "span loads same start");
      chk({35'h0, zBusy}, 36'h0, "zero count idle");
   endtask : tKeepZ

   task automatic tFg();
      // colour replicated for an 8-bit bitmap
      wr(ZISF_OFS_FG, 32'h3c3c_3c3c);
      chk({4'h0, fgColour}, 36'h0_3c3c_3c3c, "fg write");
      // 12-bit colour in both RGB sets; plane mask lies outside
      wr(ZISF_OFS_FG, 32'h0055_aa33);
      chk({4'h0, fgColour}, 36'h0_0055_aa33, "fg 12-bit write");
      wr(ZISF_OFS_RED_STEP, 32'h1111_2222);
      chk({4'h0, fgColour}, 36'h0_1111_2222, "red step alters fg");
      wr(ZISF_OFS_BLUE_STEP, 32'h7654_abcd);
      chk({4'h0, fgColour}, 36'h0_7654_abcd, "blue step alters fg");
      rdChk(ZISF_OFS_FG, 32'hffff_ffff, 32'h7654_abcd);
      rdChk(8'h40, 32'hffff_ffff, 32'h0);
   endtask : tFg

   task automatic tSubst();
      logic [31:0] pat;
      logic [31:0] d;
      pat = 32'hf0f0_0ff0;
      wr(ZISF_OFS_PATTERN, pat);
      // Every non-simple mode; fill modes take the pattern
      for (int m = 1; m <= 6; m++) begin
         wr(ZISF_OFS_CTRL, 32'(m));
         d = 32'h0000_0100 << m;
         pulse(1'b0, d);
         substChk((m >= 5) ? pat : d);
      end
      wr(ZISF_OFS_CTRL, 32'h3);
      pulse(1'b1, 32'h00a5_5a00);
      substChk(32'h00a5_5a00);
      wr(ZISF_OFS_SLOPE, 32'h0);
      substChk(pat);
      // Illegal mode code falls back to simple
      wr(ZISF_OFS_CTRL, 32'h7);
      rdChk(ZISF_OFS_CTRL, 32'hffff_ffff, 32'h0);
      pulse(1'b0, 32'hdead_0001);
      chk({35'h0, substValid}, 36'h0, "simple no pulse");
      chk({4'h0, substMask}, {4'h0, pat}, "simple mask held");
   endtask : tSubst

   // Reset pulled mid-run, while the Z, stencil, foreground and pattern registers hold nonzero data and CTRL is zero
   task automatic tMidReset();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      #1;
      tResetVals();
   endtask : tMidReset

   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      #1;
      tResetVals();
      tZRegs();
      tInterp();
      tKeepZ();
      tFg();
      tSubst();
      tMidReset();
      summarize();
   end
endmodule : z_interpolator_setup_and_foreground_bench
